//--- rtl/pcsf_flag_bank.sv
// Status flag bank of the two pulse channels with an AXI4-Lite slave
`timescale 1ns/1ps
module pcsf_flag_bank #(
    parameter int NUM_CH = 2
) (
    input  wire logic                               mclk,
    input  wire logic                               arst_n,
    // AXI4-Lite write address and data
    input  wire logic [pcsf_pkg::ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic                               s_axi_awvalid,
    output logic                                    s_axi_awready,
    input  wire logic [31:0]                        s_axi_wdata,
    input  wire logic [3:0]                         s_axi_wstrb,
    input  wire logic                               s_axi_wvalid,
    output logic                                    s_axi_wready,
    output logic [1:0]                              s_axi_bresp,
    output logic                                    s_axi_bvalid,
    input  wire logic                               s_axi_bready,
    // AXI4-Lite read
    input  wire logic [pcsf_pkg::ADDR_W-1:0]        s_axi_araddr,
    input  wire logic                               s_axi_arvalid,
    output logic                                    s_axi_arready,
    output logic [31:0]                             s_axi_rdata,
    output logic [1:0]                              s_axi_rresp,
    output logic                                    s_axi_rvalid,
    input  wire logic                               s_axi_rready,
    // Fault pins, asynchronous
    input  wire pcsf_pkg::pcsf_pins_t [NUM_CH-1:0]  pin_in,
    // Preset and sequencer side, same clock
    input  wire logic [NUM_CH-1:0]                  preset_load_action,
    input  wire logic [NUM_CH-1:0]                  preset_value_invalid,
    input  wire logic [NUM_CH-1:0]                  param_done,
    input  wire logic [NUM_CH-1:0]                  seq_level_a,
    output logic [NUM_CH-1:0]                       load_accept,
    output logic [NUM_CH-1:0]                       output_a,
    output logic [NUM_CH-1:0]                       output_b,
    output logic                                    irq
);
    localparam int PIN_W = $bits(pcsf_pkg::pcsf_pins_t) * NUM_CH;

    // The map and the interrupt layout hold two channels at most
    if (NUM_CH < 1 || NUM_CH > pcsf_pkg::MAX_CH) begin : g_bad_ch
        $error("NUM_CH must be 1 or 2");
    end

    // Byte addresses of the feedback bytes
    localparam logic [pcsf_pkg::ADDR_W-1:0] A_CH0_ERR =
        pcsf_pkg::ADDR_W'(pcsf_pkg::IDX_CH0_ERR * 4);
    localparam logic [pcsf_pkg::ADDR_W-1:0] A_CH0_STS =
        pcsf_pkg::ADDR_W'(pcsf_pkg::IDX_CH0_STS * 4);
    localparam logic [pcsf_pkg::ADDR_W-1:0] A_CH1_ERR =
        pcsf_pkg::ADDR_W'(pcsf_pkg::IDX_CH1_ERR * 4);
    localparam logic [pcsf_pkg::ADDR_W-1:0] A_CH1_STS =
        pcsf_pkg::ADDR_W'(pcsf_pkg::IDX_CH1_STS * 4);

    logic [PIN_W-1:0]          sync1_r, sync2_r, sync3_r, pin_vec_r;
    pcsf_pkg::pcsf_pins_t [NUM_CH-1:0] pins_s;
    logic [31:0]               ctrl_r;
    logic [15:0]               irq_sts_r, irq_mask_r, irq_ev;
    logic [15:0]               err_prev_r, err_now;
    pcsf_pkg::pcsf_flags_t     flags_vis [pcsf_pkg::MAX_CH];
    logic                      two_ch;

    // Write channel state
    logic                      aw_hold_r, w_hold_r, bvalid_r;
    logic [pcsf_pkg::ADDR_W-1:0] aw_addr_r;
    logic [31:0]               w_data_r;
    logic [3:0]                w_strb_r;
    logic [1:0]                bresp_r;
    logic                      wr_fire, wr_hit, aw_take, w_take;
    logic [31:0]               wr_mask;

    // Read channel state
    logic                      rvalid_r;
    logic [31:0]               rdata_r;
    logic [1:0]                rresp_r;
    logic [pcsf_pkg::ADDR_W-1:0] ar_addr_r;
    logic                      ar_take;
    logic [31:0]               rd_word;
    logic                      rd_hit;

    assign two_ch = ctrl_r[pcsf_pkg::CBIT_TWO_CH];

    // Three-stage pin synchroniser
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Accept a level once two late stages agree, filtering one-cycle glitches
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pin_vec_r <= '0;
        end else begin
            for (int i = 0; i < PIN_W; i++) begin
                if (sync2_r[i] == sync3_r[i]) begin
                    pin_vec_r[i] <= sync3_r[i];
                end
            end
        end
    end

    assign pins_s = pin_vec_r;

    // One flag block per channel
    for (genvar c = 0; c < pcsf_pkg::MAX_CH; c++) begin : g_ch
        if (c < NUM_CH) begin : g_on
            pcsf_pkg::pcsf_ctrl_t  ctrl_c;
            pcsf_pkg::pcsf_flags_t flags_c;
            logic [7:0]            cb;

            assign cb                = ctrl_r[c*8 +: 8];
            assign ctrl_c.clear      = cb[pcsf_pkg::CBIT_CLEAR];
            assign ctrl_c.source_sel = cb[pcsf_pkg::CBIT_SOURCE];
            assign ctrl_c.level_a    = cb[pcsf_pkg::CBIT_LEVEL_A];
            assign ctrl_c.level_b    = cb[pcsf_pkg::CBIT_LEVEL_B];
            assign ctrl_c.continuous = cb[pcsf_pkg::CBIT_CONT];

            pcsf_channel u_ch (
                .mclk          (mclk),
                .arst_n        (arst_n),
                .pins          (pins_s[c]),
                .ctrl          (ctrl_c),
                .load_action   (preset_load_action[c]),
                .value_invalid (preset_value_invalid[c]),
                .param_done    (param_done[c]),
                .seq_level_a   (seq_level_a[c]),
                .load_accept   (load_accept[c]),
                .output_a      (output_a[c]),
                .output_b      (output_b[c]),
                .flags         (flags_c)
            );

            // Channel 1 is hidden unless two channels are configured
            assign flags_vis[c] = (c == 0 || two_ch) ? flags_c : '0; // [RULE10]
        end else begin : g_off
            assign flags_vis[c] = '0; // [RULE10]
        end
        assign err_now[c*8 +: 8] = flags_vis[c].error;
    end

    // Interrupt events are rising edges of the visible error flags
    assign irq_ev = err_now & ~err_prev_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            err_prev_r <= pcsf_pkg::IRQ_RST;
        end else begin
            err_prev_r <= err_now;
        end
    end

    // Handshakes: one write in flight; both halves parked until answered
    assign aw_take       = s_axi_awvalid & s_axi_awready;
    assign w_take        = s_axi_wvalid & s_axi_wready;
    assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
    assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
    assign wr_fire       = aw_hold_r & w_hold_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wr_mask[b*8 +: 8] = {8{w_strb_r[b]}};
        end
    end

    assign wr_hit = (aw_addr_r == pcsf_pkg::ADDR_CTRL)
                 || (aw_addr_r == pcsf_pkg::ADDR_IRQ_STS)
                 || (aw_addr_r == pcsf_pkg::ADDR_IRQ_MASK)
                 || (aw_addr_r == A_CH0_ERR) || (aw_addr_r == A_CH0_STS)
                 || (aw_addr_r == A_CH1_ERR) || (aw_addr_r == A_CH1_STS);

    // Capture of write address and data, in either order
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
        end else begin
            if (aw_take) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold_r <= 1'b0;
            end
            if (w_take) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    // Write response; feedback bytes are read-only and ignore data
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bvalid_r <= 1'b0;
            bresp_r  <= pcsf_pkg::RESP_OKAY;
        end else begin
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? pcsf_pkg::RESP_OKAY
                                   : pcsf_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Control register steers the channels
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= pcsf_pkg::CTRL_RST;
        end else if (wr_fire && aw_addr_r == pcsf_pkg::ADDR_CTRL) begin
            ctrl_r <= (ctrl_r & ~wr_mask) | (w_data_r & wr_mask);
        end
    end

    // Mask register, same layout as the status
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_r <= pcsf_pkg::IRQ_RST;
        end else if (wr_fire && aw_addr_r == pcsf_pkg::ADDR_IRQ_MASK) begin
            irq_mask_r <= (irq_mask_r & ~wr_mask[15:0])
                        | (w_data_r[15:0] & wr_mask[15:0]);
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_sts_r <= pcsf_pkg::IRQ_RST;
        end else if (wr_fire && aw_addr_r == pcsf_pkg::ADDR_IRQ_STS) begin
            irq_sts_r <= (irq_sts_r & ~(w_data_r[15:0] & wr_mask[15:0]))
                       | irq_ev;
        end else begin
            irq_sts_r <= irq_sts_r | irq_ev;
        end
    end

    assign irq = |(irq_sts_r & irq_mask_r);

    // Read decode; unmapped addresses answer with an error and zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            A_CH0_ERR:               rd_word[7:0]  = flags_vis[0].error;
            A_CH0_STS:               rd_word[7:0]  = flags_vis[0].status;
            A_CH1_ERR:               rd_word[7:0]  = flags_vis[1].error;
            A_CH1_STS:               rd_word[7:0]  = flags_vis[1].status;
            pcsf_pkg::ADDR_CTRL:     rd_word       = ctrl_r;
            pcsf_pkg::ADDR_IRQ_STS:  rd_word[15:0] = irq_sts_r;
            pcsf_pkg::ADDR_IRQ_MASK: rd_word[15:0] = irq_mask_r;
            default:                 rd_hit        = 1'b0;
        endcase
    end

    // Read channel: one read in flight, answer one cycle after the take
    assign ar_take       = s_axi_arvalid & s_axi_arready;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= pcsf_pkg::RESP_OKAY;
            ar_addr_r <= '0;
        end else if (ar_take) begin
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_word;
            rresp_r   <= rd_hit ? pcsf_pkg::RESP_OKAY
                                : pcsf_pkg::RESP_SLVERR;
            ar_addr_r <= s_axi_araddr;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    sequence s_both_parked;
        aw_hold_r && w_hold_r && !bvalid_r;
    endsequence

    sequence s_answer;
        bvalid_r;
    endsequence

    chk_write_answer: assert property (@(posedge mclk) disable iff (!arst_n)
        s_both_parked |=> s_answer) else $error("write not answered");
    chk_bvalid_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        bvalid_r && !s_axi_bready |=> bvalid_r) else $error("bvalid dropped");
    chk_rvalid_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        rvalid_r && !s_axi_rready |=> rvalid_r && $stable(rdata_r))
        else $error("read answer changed");
    chk_ch1_hidden: assert property (@(posedge mclk) disable iff (!arst_n)
        !two_ch ##1 $rose(rvalid_r) && !two_ch
        && (ar_addr_r == A_CH1_ERR || ar_addr_r == A_CH1_STS)
        |-> rdata_r == 32'h0000_0000) else $error("ch1 visible"); // [RULE10]
    chk_reserved_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(rvalid_r) && (ar_addr_r == A_CH0_ERR || ar_addr_r == A_CH0_STS)
        |-> rdata_r[31:8] == 24'h000000 && rdata_r[6] == 1'b0
        && rdata_r[3] == 1'b0) else $error("reserved bit set"); // [RULE12]
    chk_event_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
        |irq_ev |=> (irq_sts_r & $past(irq_ev)) == $past(irq_ev))
        else $error("event lost");
endmodule : pcsf_flag_bank

//--- include/pcsf_pkg.sv
// Constants, types and register map of the pulse channel status flag bank
package pcsf_pkg;
    // Summary of operation
    // RULE1: Undervoltage flag only when supply present, low
    // RULE2: Sensor supply short sets sticky fault flag
    // RULE3: Failed single-shot preset load sets load error
    // RULE4: Load error refuses loads until clear request
    // RULE5: Output A short sets sticky fault flag
    // RULE6: Output B short or both-high sets flag
    // RULE7: Continuous mode flags invalid preset value
    // RULE8: Each accepted single-shot load flips acknowledge
    // RULE9: Ready flag shows parameterized, operational state
    // RULE10: Channel 1 bytes exist only in two-channel setup
    // RULE11: Clear request clears the four sticky faults
    // RULE12: Undescribed flag bits read as zero

    localparam int MAX_CH      = 2;
    localparam int ADDR_W      = 8;
    localparam int SYNC_STAGES = 3;

    // Register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_CH0_ERR = 8'h00;
    localparam logic [ADDR_W-1:0] IDX_CH0_STS = 8'h01;
    localparam logic [ADDR_W-1:0] IDX_CH1_ERR = 8'h08;
    localparam logic [ADDR_W-1:0] IDX_CH1_STS = 8'h09;
    // Control and interrupt registers
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STS  = 8'h44;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h48;

    // Error byte bit positions
    localparam int BIT_UNDERVOLT = 0;
    localparam int BIT_SENSOR    = 1;
    localparam int BIT_LOAD_ERR  = 2;
    localparam int BIT_OUT_A     = 4;
    localparam int BIT_OUT_B     = 5;
    localparam int BIT_INVALID   = 7;
    // Status byte bit positions
    localparam int BIT_LOAD_ACK  = 2;
    localparam int BIT_READY     = 4;

    // Control register: one byte per channel, then configuration
    localparam int CBIT_CLEAR   = 0;
    localparam int CBIT_SOURCE  = 1;
    localparam int CBIT_LEVEL_A = 3;
    localparam int CBIT_LEVEL_B = 4;
    localparam int CBIT_CONT    = 5;
    localparam int CBIT_TWO_CH  = 16;

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] IRQ_RST  = 16'h0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Synchronised pin levels of one channel
    typedef struct packed {
        logic supply_present;
        logic supply_low;
        logic sensor_short;
        logic out_a_short;
        logic out_b_short;
    } pcsf_pins_t;

    // Control bits of one channel
    typedef struct packed {
        logic clear;
        logic source_sel;
        logic level_a;
        logic level_b;
        logic continuous;
    } pcsf_ctrl_t;

    // Feedback image of one channel
    typedef struct packed {
        logic [7:0] error;
        logic [7:0] status;
    } pcsf_flags_t;
endpackage : pcsf_pkg

//--- rtl/pcsf_channel.sv
// Flag logic and output drive of one pulse channel
`timescale 1ns/1ps
module pcsf_channel (
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    input  wire pcsf_pkg::pcsf_pins_t  pins,
    input  wire pcsf_pkg::pcsf_ctrl_t  ctrl,
    input  wire logic                  load_action,
    input  wire logic                  value_invalid,
    input  wire logic                  param_done,
    input  wire logic                  seq_level_a,
    output logic                       load_accept,
    output logic                       output_a,
    output logic                       output_b,
    output pcsf_pkg::pcsf_flags_t      flags
);
    logic uv_r, sens_r, lderr_r, outa_r, outb_r, inval_r, ack_r, ready_r;
    logic load_try, manual_both;

    // Loads are taken only in single-shot mode and with no error pending
    assign load_try    = load_action & ~ctrl.continuous;
    assign load_accept = load_try & ~lderr_r & ~value_invalid; // [RULE4]
    assign manual_both = ~ctrl.source_sel & ctrl.level_a & ctrl.level_b;

    // Level flags follow their cause each cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            uv_r    <= 1'b0;
            inval_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            uv_r    <= pins.supply_present & pins.supply_low; // [RULE1]
            inval_r <= ctrl.continuous & value_invalid;       // [RULE7]
            ready_r <= param_done;                            // [RULE9]
        end
    end

    // Sticky faults; a new fault wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sens_r  <= 1'b0;
            lderr_r <= 1'b0;
            outa_r  <= 1'b0;
            outb_r  <= 1'b0;
        end else begin
            sens_r  <= pins.sensor_short | (sens_r & ~ctrl.clear); // [RULE2] [RULE11]
            lderr_r <= (load_try & ~lderr_r & value_invalid)
                     | (lderr_r & ~ctrl.clear);                  // [RULE3] [RULE11]
            outa_r  <= pins.out_a_short | (outa_r & ~ctrl.clear);  // [RULE5] [RULE11]
            outb_r  <= pins.out_b_short | manual_both
                     | (outb_r & ~ctrl.clear);                   // [RULE6] [RULE11]
        end
    end

    // Acknowledge flips once per accepted load
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= ack_r ^ load_accept; // [RULE8]
        end
    end

    // Manual drive keeps B low while A is requested
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            output_a <= 1'b0;
            output_b <= 1'b0;
        end else begin
            output_a <= ctrl.source_sel ? seq_level_a : ctrl.level_a;
            output_b <= ~ctrl.source_sel & ctrl.level_b & ~ctrl.level_a;
        end
    end

    // Undescribed positions stay zero
    always_comb begin
        flags = '0; // [RULE12]
        flags.error[pcsf_pkg::BIT_UNDERVOLT] = uv_r;
        flags.error[pcsf_pkg::BIT_SENSOR]    = sens_r;
        flags.error[pcsf_pkg::BIT_LOAD_ERR]  = lderr_r;
        flags.error[pcsf_pkg::BIT_OUT_A]     = outa_r;
        flags.error[pcsf_pkg::BIT_OUT_B]     = outb_r;
        flags.error[pcsf_pkg::BIT_INVALID]   = inval_r;
        flags.status[pcsf_pkg::BIT_LOAD_ACK] = ack_r;
        flags.status[pcsf_pkg::BIT_READY]    = ready_r;
    end

    sequence s_failed_load;
        load_try && !lderr_r && value_invalid;
    endsequence

    chk_absent_supply_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
        !pins.supply_present |=> !uv_r) else $error("undervolt without supply"); // [RULE1]
    chk_sensor_fault_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
        pins.sensor_short ##1 !ctrl.clear[*2] |-> sens_r) else $error("sensor lost"); // [RULE2]
    chk_load_fail_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        s_failed_load |=> lderr_r) else $error("load error not set"); // [RULE3]
    chk_load_refused: assert property (@(posedge mclk) disable iff (!arst_n)
        lderr_r |=> ack_r == $past(ack_r))
        else $error("load taken under error"); // [RULE4]
    chk_out_a_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
        outa_r && !ctrl.clear |=> outa_r) else $error("output A flag lost"); // [RULE5]
    chk_manual_both_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        manual_both |=> outb_r && !output_b) else $error("both-high missed"); // [RULE6]
    chk_invalid_value: assert property (@(posedge mclk) disable iff (!arst_n)
        ctrl.continuous && $rose(value_invalid) |=> $rose(inval_r))
        else $error("invalid value not flagged"); // [RULE7]
    chk_ack_flip: assert property (@(posedge mclk) disable iff (!arst_n)
        load_accept |=> ack_r != $past(ack_r)) else $error("ack not flipped"); // [RULE8]
    chk_ready_follow: assert property (@(posedge mclk) disable iff (!arst_n)
        ##1 ready_r == $past(param_done)) else $error("ready mismatch"); // [RULE9]
    chk_clear_faults: assert property (@(posedge mclk) disable iff (!arst_n)
        ctrl.clear && !pins.sensor_short && !pins.out_a_short
        && !pins.out_b_short && !manual_both && !load_try
        |=> !sens_r && !outa_r && !outb_r && !lderr_r)
        else $error("clear failed"); // [RULE11]
endmodule : pcsf_channel

//--- tb/pcsf_field_model.sv
// Field wiring model: an output A short only shows while A drives high
`timescale 1ns/1ps
module pcsf_field_model (
    input  wire logic                       mclk,
    input  wire pcsf_pkg::pcsf_pins_t [1:0] field,
    input  wire logic [1:0]                 short_a,
    input  wire logic [1:0]                 output_a,
    output pcsf_pkg::pcsf_pins_t [1:0]      pin_in
);
    // Pins move just after an edge, as real wiring seen by the sampler
    always_ff @(posedge mclk) begin
        for (int c = 0; c < 2; c++) begin
            pin_in[c]             <= field[c];
            pin_in[c].out_a_short <= short_a[c] & output_a[c];
        end
    end
endmodule : pcsf_field_model

//--- tb/pcsf_flag_bank_bench.sv
// Self-checking bench of the two-channel status flag bank
`timescale 1ns/1ps
module pcsf_flag_bank_bench;
    localparam logic [7:0] E0 = pcsf_pkg::IDX_CH0_ERR << 2;
    localparam logic [7:0] S0 = pcsf_pkg::IDX_CH0_STS << 2;
    localparam logic [7:0] E1 = pcsf_pkg::IDX_CH1_ERR << 2;
    localparam logic [7:0] CT = pcsf_pkg::ADDR_CTRL;
    logic mclk = 1'b0, arst_n = 1'b0, irq, s_axi_awready, s_axi_wready;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, acc;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, load_accept, output_a, output_b;
    logic [1:0]  preset_load_action = '0, preset_value_invalid = '0;
    logic [1:0]  param_done = '0, seq_level_a = '0, short_a = '0;
    pcsf_pkg::pcsf_pins_t [1:0] pin_in, field = '0;
    int mismatches = 0, n_compared = 0;

    always #2 mclk = ~mclk;

    pcsf_flag_bank DUT (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
        .preset_load_action, .preset_value_invalid, .param_done,
        .seq_level_a, .load_accept, .output_a, .output_b, .irq);
    pcsf_field_model fm (.mclk, .field, .short_a, .output_a, .pin_in);

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // Address and data offered together, each dropped once taken
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        bit pa = 1'b1;
        bit pw = 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (pa | pw) begin
            @(posedge mclk);
            if (s_axi_awready) pa = 1'b0;
            if (s_axi_wready) pw = 1'b0;
            s_axi_awvalid <= pa;
            s_axi_wvalid  <= pw;
        end
        s_axi_bready <= 1'b1;
        do @(posedge mclk); while (!s_axi_bvalid);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : w

    task automatic rc(input string nm, input logic [7:0] a, logic [31:0] e);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do @(posedge mclk); while (!s_axi_rvalid);
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(nm, s_axi_rdata, e);
    endtask : rc

    // Accept is sampled in the cycle the one-cycle request stands
    task automatic pulse;
        preset_load_action[0] <= 1'b1;
        @(posedge mclk);
        acc = load_accept[0];
        preset_load_action[0] <= 1'b0;
        @(posedge mclk);
    endtask : pulse

    task automatic t_supply;
        field[0].supply_present <= 1'b1;
        field[0].supply_low     <= 1'b1;
        tick(8);
        rc("undervolt", E0, 32'h01);
        field[0].supply_present <= 1'b0;
        tick(8);
        rc("absent", E0, 32'h00);
    endtask : t_supply

    task automatic t_sensor;
        w(pcsf_pkg::ADDR_IRQ_MASK, 32'h02);
        field[0].sensor_short <= 1'b1;
        tick(8);
        field[0].sensor_short <= 1'b0;
        tick(8);
        rc("sensor", E0, 32'h02);
        chk("irq", irq, 1'b1);
        w(pcsf_pkg::ADDR_IRQ_STS, 32'h02);
        tick(1);
        chk("irq off", irq, 1'b0);
        w(CT, 32'h01);
        w(CT, 32'h00);
        rc("cleared", E0, 32'h00);
    endtask : t_sensor

    task automatic t_outs;
        w(CT, 32'h08);
        short_a[0] <= 1'b1;
        tick(8);
        short_a[0] <= 1'b0;
        w(CT, 32'h18);
        tick(2);
        chk("out b", output_b[0], 1'b0);
        chk("out a", output_a[0], 1'b1);
        rc("out faults", E0, 32'h30);
        w(CT, 32'h01);
        rc("out clr", E0, 32'h00);
    endtask : t_outs

    task automatic t_load;
        param_done[0] <= 1'b1;
        w(CT, 32'h00);
        rc("ready", S0, 32'h10);
        pulse;
        chk("accept", acc, 1'b1);
        rc("ack", S0, 32'h14);
        preset_value_invalid[0] <= 1'b1;
        pulse;
        chk("bad load", acc, 1'b0);
        preset_value_invalid[0] <= 1'b0;
        rc("load err", E0, 32'h04);
        pulse;
        chk("refused", acc, 1'b0);
        rc("no ack", S0, 32'h14);
        w(CT, 32'h01);
        w(CT, 32'h20);
        preset_value_invalid[0] <= 1'b1;
        tick(1); // Flag is registered, one edge behind its cause
        rc("invalid", E0, 32'h80);
        preset_value_invalid[0] <= 1'b0;
        tick(2);
        rc("valid", E0, 32'h00);
    endtask : t_load

    task automatic t_ch1;
        field[1].supply_present <= 1'b1;
        field[1].supply_low     <= 1'b1;
        tick(8);
        rc("ch1 off", E1, 32'h00);
        w(CT, 32'h10000);
        rc("ch1 on", E1, 32'h01);
        w(8'h10, 32'hFF);
        chk("wr slverr", rr, pcsf_pkg::RESP_SLVERR);
        rc("unmapped", 8'h10, 32'h00);
        chk("slverr", rr, pcsf_pkg::RESP_SLVERR);
    endtask : t_ch1

    initial begin
        tick(12);
        arst_n <= 1'b1;
        tick(1);
        t_supply;
        t_sensor;
        t_outs;
        t_load;
        t_ch1;
        complete_run;
    end

    // Watchdog: whole run needs well under two thousand cycles
    initial begin
        #100000;
        mismatches++;
        complete_run;
    end
endmodule : pcsf_flag_bank_bench
